/* verilog/anr_regs.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "anr_params.svh"
// Overview of operation
// - Partner ability register loads the partner's received base page.
// - With next pages, later pages may overwrite it after completion.
// - Partner acknowledge bit 14 follows only the negotiation engine.
// - Bits 15 and 13 show partner next page request and fault.
// - Bits 11 and 10 show partner asymmetric and symmetric pause.
// - Bits 9 to 5 show partner speed and duplex abilities.
// - Bits 4 to 0 hold partner selector, reset to zero.
// - Ability bit 12 reads zero; software writes it as zero.
// - Expansion bits 15 to 7 ignore writes and read zero.
// - Expansion bit 6 reads one: location bit is meaningful.
// - Expansion bit 5 reads one: partner next pages in register 5.
// - Expansion bit 4 shows a parallel detection fault.
// - Expansion bit 3 shows partner next page ability.
// - Expansion bit 2 reads fixed one: local next page able.
// - Expansion bit 1 sets on page received, clears on read.
// - Expansion bit 0 shows partner negotiation ability.
// - Next page transmit register holds the page sent to partner.
// - Bit 13 resets to one; selects message or unformatted page.
// - Read-only bit 11 is inverse of last exchanged toggle.
// - Code field bits 10 to 0 writable, reset to null page.
module anr_regs
	import anr_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              srst,
	// Management register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	// Pages from the negotiation engine
	input  wire logic              base_page_valid,
	input  wire logic [15:0]       base_page_word,
	input  wire logic              next_page_valid,
	input  wire logic [15:0]       next_page_word,
	input  wire logic              an_complete,
	input  wire logic              partner_ack,
	// Status levels and events
	input  wire logic              parallel_fault,
	input  wire logic              partner_local_extra_page_capable,
	input  wire logic              partner_an_able,
	input  wire logic              page_received,
	input  wire logic              lcw_exchanged,
	input  wire logic              lcw_toggle,
	// Page to transmit
	output logic      [15:0]       np_tx_word
);

	anr_stat_if     st ();
	anr_reg_state_t r_reg;
	anr_reg_state_t r_next;
	logic           hit_lpa;
	logic           hit_exp;
	logic           hit_npt;

	anr_rx_status u_rx_status (
		.clock           (clock),
		.srst            (srst),
		.base_page_valid (base_page_valid),
		.base_page_word  (base_page_word),
		.next_page_valid (next_page_valid),
		.next_page_word  (next_page_word),
		.an_complete     (an_complete),
		.partner_ack     (partner_ack),
		.parallel_fault  (parallel_fault),
		.partner_local_extra_page_capable (partner_local_extra_page_capable),
		.partner_an_able (partner_an_able),
		.page_received   (page_received),
		.lcw_exchanged   (lcw_exchanged),
		.lcw_toggle      (lcw_toggle),
		.st              (st.status)
	);

	assign hit_lpa = (reg_addr == ADDR_W'(`ANR_OFF_LPA));
	assign hit_exp = (reg_addr == ADDR_W'(`ANR_OFF_EXP));
	assign hit_npt = (reg_addr == ADDR_W'(`ANR_OFF_NPT));

	// Reading the expansion word is what acknowledges a page event
	assign st.clr_page_rx = reg_rd && hit_exp;

	always_comb
	begin
		r_next       = r_reg;
		r_next.rdata = `ANR_ZERO16;
		// Only writable fields take the data; others are cleared to zero
		if (reg_wr && hit_npt)
			r_next.npt = reg_wdata & `ANR_NPT_WMASK;
		if (reg_rd)
		begin
			if (hit_lpa)
				r_next.rdata = st.lpa_word;
			else if (hit_exp)
				r_next.rdata = st.exp_word;
			else if (hit_npt)
			begin
				r_next.rdata = r_reg.npt;
				r_next.rdata[`ANR_NPT_TOG] = st.sync_toggle;
			end
		end
		if (srst)
		begin
			r_next.npt   = `ANR_NPT_RST;
			r_next.rdata = `ANR_ZERO16;
		end
	end

	always_ff @(posedge clock)
	begin
		r_reg <= r_next;
	end

	assign reg_rdata = r_reg.rdata;

	always_comb
	begin
		np_tx_word               = r_reg.npt;
		np_tx_word[`ANR_NPT_ACK] = 1'b0;
		np_tx_word[`ANR_NPT_TOG] = st.sync_toggle;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	a_lpa_base_load: assert property (
		base_page_valid |=>
		((st.lpa_word & `ANR_LPA_LOADMASK) ==
		($past(base_page_word) & `ANR_LPA_LOADMASK)))
		else $error("partner ability not loaded from base page");

	a_lpa_late_page: assert property (
		(!base_page_valid && next_page_valid && an_complete &&
		partner_local_extra_page_capable) |=>
		((st.lpa_word & `ANR_LPA_LOADMASK) ==
		($past(next_page_word) & `ANR_LPA_LOADMASK)))
		else $error("partner ability not overwritten by late page");

	a_lpa_no_early: assert property (
		(!base_page_valid && !(next_page_valid && an_complete &&
		partner_local_extra_page_capable)) |=> $stable(st.lpa_word & `ANR_LPA_LOADMASK))
		else $error("partner ability changed without a page");

	a_lpa_ack_follow: assert property (
		##1 st.lpa_word[`ANR_LPA_ACK] == $past(partner_ack))
		else $error("acknowledge bit does not follow engine");

	a_lpa_read_back: assert property (
		(reg_rd && hit_lpa) |=> (reg_rdata == $past(st.lpa_word)))
		else $error("partner ability read data wrong");

	a_lpa_rsv_zero: assert property (
		(reg_rd && hit_lpa) |=> !reg_rdata[`ANR_LPA_RSV])
		else $error("reserved ability bit read as one");

	a_exp_fixed: assert property (
		(reg_rd && hit_exp) |=>
		(reg_rdata[`ANR_EXP_RSV_HI:`ANR_EXP_RSV_LO] == '0) &&
		reg_rdata[`ANR_EXP_LOC_ABLE] && reg_rdata[`ANR_EXP_LOC] &&
		reg_rdata[`ANR_EXP_NPABLE])
		else $error("expansion constant bits wrong");

	a_exp_pdf: assert property (
		parallel_fault |=> st.exp_word[`ANR_EXP_PDF])
		else $error("parallel detect fault not shown");

	a_exp_lpnp: assert property (
		##1 st.exp_word[`ANR_EXP_LPNP] == $past(partner_local_extra_page_capable))
		else $error("partner next page ability not shown");

	a_exp_lpan: assert property (
		##1 st.exp_word[`ANR_EXP_LPAN] == $past(partner_an_able))
		else $error("partner negotiation ability not shown");

	// A read right after the set may legally clear the flag again
	a_page_rx_set: assert property (
		page_received |=> st.exp_word[`ANR_EXP_PAGERX] ##1
		(st.exp_word[`ANR_EXP_PAGERX] || $past(reg_rd && hit_exp)))
		else $error("page received flag not sticky");

	a_page_rx_clear: assert property (
		(reg_rd && hit_exp && !page_received) |=>
		!st.exp_word[`ANR_EXP_PAGERX])
		else $error("page received flag not cleared on read");

	a_page_rx_hold: assert property (
		(!page_received && !(reg_rd && hit_exp)) |=>
		$stable(st.exp_word[`ANR_EXP_PAGERX]))
		else $error("page received flag changed on its own");

	a_npt_write: assert property (
		(reg_wr && hit_npt) |=>
		((np_tx_word & `ANR_NPT_WMASK) ==
		($past(reg_wdata) & `ANR_NPT_WMASK)))
		else $error("next page word write failed");

	a_npt_hold: assert property (
		!(reg_wr && hit_npt) |=>
		$stable(np_tx_word & `ANR_NPT_WMASK))
		else $error("next page word changed without write");

	a_npt_ack_zero: assert property (
		##1 !np_tx_word[`ANR_NPT_ACK])
		else $error("read-only acknowledge bit set");

	a_npt_toggle: assert property (
		lcw_exchanged |=>
		(np_tx_word[`ANR_NPT_TOG] == !$past(lcw_toggle)))
		else $error("toggle bit not inverse of exchanged toggle");

	a_npt_tog_hold: assert property (
		!lcw_exchanged |=> $stable(np_tx_word[`ANR_NPT_TOG]))
		else $error("toggle bit changed without an exchange");

	a_npt_tog_reset: assert property (
		$fell(srst) |-> !np_tx_word[`ANR_NPT_TOG])
		else $error("toggle bit not cleared by reset");

	a_npt_read_tog: assert property (
		(reg_rd && hit_npt) |=>
		(reg_rdata[`ANR_NPT_TOG] == $past(st.sync_toggle)))
		else $error("toggle bit read data wrong");

	a_npt_read: assert property (
		(reg_rd && hit_npt) |=> (reg_rdata == $past(np_tx_word)))
		else $error("next page word read data wrong");

	a_rdata_idle: assert property (
		!reg_rd |=> (reg_rdata == `ANR_ZERO16))
		else $error("read data present without a read");

	a_rdata_unmapped: assert property (
		(reg_rd && !hit_lpa && !hit_exp && !hit_npt) |=>
		(reg_rdata == `ANR_ZERO16))
		else $error("unmapped read returned data");

	a_npt_reset_val: assert property (
		$fell(srst) |-> (np_tx_word & `ANR_NPT_WMASK) == `ANR_NPT_RST)
		else $error("next page word reset value wrong");

	a_lpa_reset: assert property (
		$fell(srst) |-> (st.lpa_word == `ANR_LPA_RST))
		else $error("partner ability reset value wrong");

	a_exp_reset: assert property (
		$fell(srst) |-> (st.exp_word == `ANR_EXP_RST))
		else $error("expansion reset value wrong");

	a_exp_read_back: assert property (
		(reg_rd && hit_exp) |=> (reg_rdata == $past(st.exp_word)))
		else $error("expansion read data wrong");

	a_exp_pdf_clear: assert property (
		!parallel_fault |=> !st.exp_word[`ANR_EXP_PDF])
		else $error("parallel detect fault shown without fault");

	c_page_then_read: cover property (
		page_received ##[1:20] (reg_rd && hit_exp));

	c_set_on_clear: cover property (
		page_received && reg_rd && hit_exp);

	c_late_page: cover property (
		base_page_valid ##[1:50] (next_page_valid && an_complete));

	c_npt_write_read: cover property (
		(reg_wr && hit_npt) ##1 (reg_rd && hit_npt));

	c_reset_then_read: cover property (
		$fell(srst) ##[1:10] (reg_rd && hit_exp));

endmodule : anr_regs

/* verilog/anr_params.svh */
`ifndef ANR_PARAMS_SVH
`define ANR_PARAMS_SVH

// Register word offsets on the management port
`define ANR_OFF_LPA      5'h05
`define ANR_OFF_EXP      5'h06
`define ANR_OFF_NPT      5'h07

// Partner ability word
`define ANR_LPA_ACK      14
`define ANR_LPA_RSV      12
`define ANR_LPA_LOADMASK 16'hafff
`define ANR_LPA_RST      16'h0000

// Expansion word
`define ANR_EXP_LOC_ABLE 6
`define ANR_EXP_LOC      5
`define ANR_EXP_PDF      4
`define ANR_EXP_LPNP     3
`define ANR_EXP_NPABLE   2
`define ANR_EXP_PAGERX   1
`define ANR_EXP_LPAN     0
`define ANR_EXP_RSV_HI   15
`define ANR_EXP_RSV_LO   7
`define ANR_EXP_RST      16'h0064

// Next page transmit word
`define ANR_NPT_NP       15
`define ANR_NPT_ACK      14
`define ANR_NPT_MP       13
`define ANR_NPT_MESSAGE_COMPLY_FLAG     12
`define ANR_NPT_TOG      11
`define ANR_NPT_WMASK    16'hb7ff
`define ANR_NPT_RST      16'h2001

`define ANR_ZERO16       16'h0000

`endif

/* verilog/anr_pkg.sv */
package anr_pkg;

	typedef struct packed {
		logic [15:0] lpa;
		logic        ack;
		logic        page_rx;
		logic        parallel_detect_fault;
		logic        lpnp;
		logic        lpan;
		logic        toggle;
	} anr_rx_state_t;

	typedef struct packed {
		logic [15:0] npt;
		logic [15:0] rdata;
	} anr_reg_state_t;

endpackage : anr_pkg

/* verilog/anr_stat_if.sv */
`timescale 1ns/100ps
interface anr_stat_if;
	logic [15:0] lpa_word;
	logic [15:0] exp_word;
	logic        sync_toggle;
	logic        clr_page_rx;

	modport status (
		output lpa_word,
		output exp_word,
		output sync_toggle,
		input  clr_page_rx
	);

	modport regs (
		input  lpa_word,
		input  exp_word,
		input  sync_toggle,
		output clr_page_rx
	);
endinterface : anr_stat_if

/* verilog/anr_rx_status.sv */
`timescale 1ns/100ps
`include "anr_params.svh"
module anr_rx_status
	import anr_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// Pages from the negotiation engine
	input  wire logic        base_page_valid,
	input  wire logic [15:0] base_page_word,
	input  wire logic        next_page_valid,
	input  wire logic [15:0] next_page_word,
	input  wire logic        an_complete,
	input  wire logic        partner_ack,
	// Status levels and events
	input  wire logic        parallel_fault,
	input  wire logic        partner_local_extra_page_capable,
	input  wire logic        partner_an_able,
	input  wire logic        page_received,
	input  wire logic        lcw_exchanged,
	input  wire logic        lcw_toggle,
	// Register side
	anr_stat_if.status       st
);

	anr_rx_state_t s_reg;
	anr_rx_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		if (base_page_valid)
			s_next.lpa = base_page_word & `ANR_LPA_LOADMASK;
		// Late pages replace the base page once negotiation is done
		else if (next_page_valid && an_complete && partner_local_extra_page_capable)
			s_next.lpa = next_page_word & `ANR_LPA_LOADMASK;
		s_next.ack  = partner_ack;
		s_next.parallel_detect_fault  = parallel_fault;
		s_next.lpnp = partner_local_extra_page_capable;
		s_next.lpan = partner_an_able;
		// Set beats the read-clear so no page event is lost
		if (page_received)
			s_next.page_rx = 1'b1;
		else if (st.clr_page_rx)
			s_next.page_rx = 1'b0;
		if (lcw_exchanged)
			s_next.toggle = ~lcw_toggle;
		if (srst)
		begin
			s_next         = '0;
			s_next.lpa     = `ANR_LPA_RST;
		end
	end

	always_ff @(posedge clock)
	begin
		s_reg <= s_next;
	end

	always_comb
	begin
		st.lpa_word                = s_reg.lpa;
		st.lpa_word[`ANR_LPA_ACK]  = s_reg.ack;
		st.lpa_word[`ANR_LPA_RSV]  = 1'b0;
		st.exp_word                = `ANR_ZERO16;
		st.exp_word[`ANR_EXP_LOC_ABLE] = 1'b1;
		st.exp_word[`ANR_EXP_LOC]      = 1'b1;
		st.exp_word[`ANR_EXP_PDF]      = s_reg.parallel_detect_fault;
		st.exp_word[`ANR_EXP_LPNP]     = s_reg.lpnp;
		st.exp_word[`ANR_EXP_NPABLE]   = 1'b1;
		st.exp_word[`ANR_EXP_PAGERX]   = s_reg.page_rx;
		st.exp_word[`ANR_EXP_LPAN]     = s_reg.lpan;
		st.sync_toggle             = s_reg.toggle;
	end

endmodule : anr_rx_status

/* tb/anr_engine_model.sv */
`timescale 1ns/100ps
module anr_engine_model
(
	// Clock
	input  wire logic clock,
	// Pages toward the register bank
	output logic        base_page_valid,
	output logic [15:0] base_page_word,
	output logic        next_page_valid,
	output logic [15:0] next_page_word,
	// Levels and events
	output logic        an_complete,
	output logic        partner_ack,
	output logic        parallel_fault,
	output logic        partner_local_extra_page_capable,
	output logic        partner_an_able,
	output logic        page_received,
	output logic        lcw_exchanged,
	output logic        lcw_toggle
);
	initial
	begin
		{base_page_valid, next_page_valid, page_received} = 3'b000;
		{lcw_exchanged, lcw_toggle} = 2'b00;
		{an_complete, partner_ack, parallel_fault} = 3'b000;
		{partner_local_extra_page_capable, partner_an_able} = 2'b00;
		base_page_word = 16'h0000;
		next_page_word = 16'h0000;
	end

	// Order: complete, ack, fault, next page able, negotiation able
	task automatic set_levels(input logic [4:0] v);
		@(posedge clock);
		{an_complete, partner_ack, parallel_fault} <= v[4:2];
		{partner_local_extra_page_capable, partner_an_able} <= v[1:0];
	endtask : set_levels

	// Released words are inverted so a stale value never looks valid
	task automatic send_base(input logic [15:0] w);
		@(posedge clock);
		base_page_valid <= 1'b1;
		base_page_word <= w;
		@(posedge clock);
		base_page_valid <= 1'b0;
		base_page_word <= ~w;
	endtask : send_base

	task automatic send_next(input logic [15:0] w);
		@(posedge clock);
		next_page_valid <= 1'b1;
		next_page_word <= w;
		@(posedge clock);
		next_page_valid <= 1'b0;
		next_page_word <= ~w;
	endtask : send_next

	task automatic page_event();
		@(posedge clock);
		page_received <= 1'b1;
		@(posedge clock);
		page_received <= 1'b0;
	endtask : page_event

	task automatic exchange(input logic tog);
		@(posedge clock);
		lcw_exchanged <= 1'b1;
		lcw_toggle <= tog;
		@(posedge clock);
		lcw_exchanged <= 1'b0;
		lcw_toggle <= ~tog;
	endtask : exchange
endmodule : anr_engine_model

/* tb/autoneg_partner_and_next_page_regs_bench.sv */
`timescale 1ns/100ps
module autoneg_partner_and_next_page_regs_bench;
	logic        clock;
	logic        srst;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [15:0] np_tx_word;
	logic        base_page_valid;
	logic [15:0] base_page_word;
	logic        next_page_valid;
	logic [15:0] next_page_word;
	logic        an_complete;
	logic        partner_ack;
	logic        parallel_fault;
	logic        partner_local_extra_page_capable;
	logic        partner_an_able;
	logic        page_received;
	logic        lcw_exchanged;
	logic        lcw_toggle;
	int          n_errors;
	int          n_tests;
	int          cycles = 0;

	anr_engine_model eng (
		.clock           (clock),
		.base_page_valid (base_page_valid),
		.base_page_word  (base_page_word),
		.next_page_valid (next_page_valid),
		.next_page_word  (next_page_word),
		.an_complete     (an_complete),
		.partner_ack     (partner_ack),
		.parallel_fault  (parallel_fault),
		.partner_local_extra_page_capable (partner_local_extra_page_capable),
		.partner_an_able (partner_an_able),
		.page_received   (page_received),
		.lcw_exchanged   (lcw_exchanged),
		.lcw_toggle      (lcw_toggle)
	);

	anr_regs #(.ADDR_W(5)) dut (
		.clock           (clock),
		.srst            (srst),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.base_page_valid (base_page_valid),
		.base_page_word  (base_page_word),
		.next_page_valid (next_page_valid),
		.next_page_word  (next_page_word),
		.an_complete     (an_complete),
		.partner_ack     (partner_ack),
		.parallel_fault  (parallel_fault),
		.partner_local_extra_page_capable (partner_local_extra_page_capable),
		.partner_an_able (partner_an_able),
		.page_received   (page_received),
		.lcw_exchanged   (lcw_exchanged),
		.lcw_toggle      (lcw_toggle),
		.np_tx_word      (np_tx_word)
	);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic test_done();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands one cycle only, so it is sampled right then
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			test_done();
		end
	end

	initial
	begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{n_errors, n_tests} = '0;
		srst = 1'b1;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		rd(5'h05, 16'h0000);
		rd(5'h06, 16'h0064);
		rd(5'h07, 16'h2001);
		check(np_tx_word, 16'h2001);
		eng.set_levels(5'b01000);
		eng.send_base(16'hffff);
		rd(5'h05, 16'hefff);
		eng.set_levels(5'b00000);
		eng.send_base(16'h5a5a);
		rd(5'h05, 16'h0a5a);
		wr(5'h05, 16'hffff);
		rd(5'h05, 16'h0a5a);
		eng.set_levels(5'b00111);
		eng.send_next(16'h1234);
		rd(5'h05, 16'h0a5a);
		rd(5'h06, 16'h007d);
		eng.set_levels(5'b10111);
		eng.send_next(16'h1234);
		rd(5'h05, 16'h0234);
		eng.set_levels(5'b11111);
		rd(5'h05, 16'h4234);
		wr(5'h06, 16'hffff);
		rd(5'h06, 16'h007d);
		eng.page_event();
		rd(5'h06, 16'h007f);
		rd(5'h06, 16'h007d);
		eng.set_levels(5'b00000);
		rd(5'h06, 16'h0064);
		wr(5'h07, 16'hffff);
		rd(5'h07, 16'hb7ff);
		eng.exchange(1'b0);
		rd(5'h07, 16'hbfff);
		check(np_tx_word, 16'hbfff);
		eng.exchange(1'b1);
		rd(5'h07, 16'hb7ff);
		wr(5'h07, 16'h0000);
		rd(5'h07, 16'h0000);
		rd(5'h1f, 16'h0000);
		@(posedge clock);
		#1;
		check(reg_rdata, 16'h0000);
		// Mid-run reset must also drop a pending page flag
		eng.page_event();
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(5'h06, 16'h0064);
		rd(5'h07, 16'h2001);
		check(np_tx_word, 16'h2001);
		rd(5'h05, 16'h0000);
		test_done();
	end
endmodule : autoneg_partner_and_next_page_regs_bench
